//--- core/gspm_cfg.svh
// Constants for the gauge status and power mode block.
// Operation
// - Thermistor default; internal sensor when select cleared.
// - Charge overheat flag: limit, dwell, current; release.
// - Discharge overheat flag: limit, dwell, negative current.
// - Taper termination over two windows clears charging.
// - On termination optionally load remaining with full.
// - Alarm level -1: terminate only on taper.
// - Full level -1: full flag waits taper.
// - Charge block outside limits, clear within hysteresis.
// - Normal mode whenever no other mode active.
// - Sleep when enabled and current below sleep level.
// - Offset calibration runs before sleep entry from normal mode.
// - Sleep modes may hold lines low 4 ms.
// - Leave sleep modes when current rises or wake.
// - Nonzero wait counts down into deep idle.
// - Zero wait: deep idle only with host request.
// - Activity leaves deep idle; oscillator off there.
// - Deep idle exit keeps request only with wait.
// - Dormant: relaxed voltage, low current, cell or request.
// - Dormant until addressed activity; shutdown only low cell.
// - Waking from dormant clears dormant request.
// - Report pre-dormant values about 3 seconds.
// - Software reset classified and counted per type.
`ifndef GSPM_CFG_SVH
`define GSPM_CFG_SVH
`define GSPM_CLK_MHZ 100
`define GSPM_STALL_MS 4
`define GSPM_STALL_CYC (`GSPM_STALL_MS * 1000 * `GSPM_CLK_MHZ)
`define GSPM_HOLD_S 3
`define GSPM_HOLD_CYC (`GSPM_HOLD_S * 1000000 * `GSPM_CLK_MHZ)
`define GSPM_CAL_CYC 16
`define GSPM_TAPER_WINDOWS 2
`define GSPM_LEVEL_OFF 16'hFFFF
`define GSPM_RST_TYPES 4
`endif

//--- core/gspm_pkg.sv
// Types for the gauge status and power mode block.
`default_nettype none
package gspm_pkg;
  typedef enum logic [2:0] {NORMAL, CALIB, SLEEP, DEEPIDLE, DORMANT} gspm_mode_type;
endpackage
`default_nettype wire

//--- core/gspm_core.sv
// Status flags, power mode sequencer and reset counters of the gauge.
`include "gspm_cfg.svh"
`default_nettype none
module gspm_core #(
  parameter int STALL_CYC = `GSPM_STALL_CYC, // Line hold length.
  parameter int HOLD_CYC  = `GSPM_HOLD_CYC   // Post-dormant report hold.
) (
  input  wire logic               ref_clk,               // Clock.
  input  wire logic               rst,                   // Async reset.
  input  wire logic               clkEn,                 // Clock enable.
  input  wire logic               measStrobe,            // New measurements.
  input  wire logic signed [15:0] extTemp,               // Thermistor temperature.
  input  wire logic signed [15:0] intTemp,               // On-chip temperature.
  input  wire logic               thermalSourceSelect,   // 1 thermistor, 0 internal.
  input  wire logic signed [15:0] meanCellFlow,          // Average current.
  input  wire logic signed [15:0] cellVoltage,           // Voltage.
  input  wire logic        [15:0] capGain,               // Capacity gain per window.
  input  wire logic        [15:0] capGainMin,            // Least gain per window.
  input  wire logic               taperWindowEnd,        // Taper window boundary.
  input  wire logic signed [15:0] chargeHeatLimit,       // Charge overheat limit.
  input  wire logic signed [15:0] chargeHeatRelease,     // Charge overheat recovery.
  input  wire logic        [7:0]  chargeHeatDwell,       // Updates; 0 disables.
  input  wire logic signed [15:0] chgCurThresh,          // Charge current threshold.
  input  wire logic signed [15:0] dischargeHeatLimit,    // Discharge overheat limit.
  input  wire logic signed [15:0] dischargeHeatRelease,  // Discharge overheat recovery.
  input  wire logic        [7:0]  dischargeHeatDwell,    // Updates; 0 disables.
  input  wire logic signed [15:0] dsgCurThresh,          // Discharge current threshold.
  input  wire logic signed [15:0] taperCurrent,          // Taper current.
  input  wire logic signed [15:0] chargingVoltage,       // Charging voltage.
  input  wire logic signed [15:0] taperVoltage,          // Taper voltage.
  input  wire logic               remainingToFullOnEnd,  // Load remaining on end.
  input  wire logic        [15:0] fullCapacityValue,     // Full capacity.
  input  wire logic        [15:0] chargeLeftIn,          // Computed remaining.
  input  wire logic        [15:0] chargerAlarmLevel,     // 0xFFFF means -1.
  input  wire logic        [15:0] fullDetectLevel,       // 0xFFFF means -1.
  input  wire logic        [15:0] socPercent,            // State of charge.
  input  wire logic signed [15:0] inhibitLow,            // Inhibit low limit.
  input  wire logic signed [15:0] inhibitHigh,           // Inhibit high limit.
  input  wire logic signed [15:0] tempHys,               // Inhibit hysteresis.
  input  wire logic               sleepEnable,           // Sleep allowed.
  input  wire logic signed [15:0] sleepCurrent,          // Sleep level.
  input  wire logic        [15:0] deepIdleWait,          // Updates before deep idle.
  input  wire logic               wakeCompEnable,        // Wake comparator on.
  input  wire logic               wakeCompTrip,          // Wake comparator pin.
  input  wire logic               commActivity,          // Bus activity pin.
  input  wire logic               commAddressed,         // Addressed activity pin.
  input  wire logic               deepIdleSetSubcommand, // Host sets deep idle request.
  input  wire logic               dormantSetSubcommand,  // Host sets dormant request.
  input  wire logic               ocvValid,              // Relaxed voltage valid.
  input  wire logic signed [15:0] dormantCurrent,        // Dormant current level.
  input  wire logic signed [15:0] dormantVoltage,        // Low cell voltage level.
  input  wire logic               resetSubcommand,       // Software reset pulse.
  input  wire logic        [1:0]  resetType,             // Reset class.
  input  wire logic        [1:0]  resetDataSel,          // Counter to read.
  output logic signed [15:0]      batteryTemp,           // Selected temperature.
  output logic                    chargeHeatFlag,        // Charge overheat.
  output logic                    dischargeHeatFlag,     // Discharge overheat.
  output logic                    chargingFlag,          // Charging.
  output logic                    terminateCharge,       // Terminate indication.
  output logic                    fullChargeFlag,        // Full charge.
  output logic                    chargeBlockFlag,       // Charge inhibit.
  output logic             [15:0] chargeLeftValue,       // Reported remaining.
  output logic                    deepIdleRequest,       // Deep idle request bit.
  output logic                    dormantRequest,        // Dormant request bit.
  output logic             [2:0]  powerMode,             // Current mode code.
  output logic                    calibrating,           // Offset calibration run.
  output logic                    hfOscOff,              // Fast oscillator off.
  output logic                    lineHold,              // Holds comm lines low.
  output logic                    shutdownActive,        // Shutdown pin function.
  output logic                    reportFrozen,          // Pre-dormant values shown.
  output logic             [7:0]  resetCount             // Selected reset counter.
);
  logic signed [15:0] tempNow;
  logic [2:0] comSync_ff, adrSync_ff, wakSync_ff;
  logic comAct, adrAct, wakAct;
  // Pins pass three flops; only the last one is read by logic.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      comSync_ff <= 3'h0;
      adrSync_ff <= 3'h0;
      wakSync_ff <= 3'h0;
    end else if (clkEn) begin
      comSync_ff <= {comSync_ff[1:0], commActivity};
      adrSync_ff <= {adrSync_ff[1:0], commAddressed};
      wakSync_ff <= {wakSync_ff[1:0], wakeCompTrip};
    end
  end
  assign comAct = comSync_ff[2];
  assign adrAct = adrSync_ff[2];
  assign wakAct = wakSync_ff[2] & wakeCompEnable;
  assign tempNow = thermalSourceSelect ? extTemp : intTemp;

  // Flag group.
  logic [7:0] chtCnt_ff, nxt_chtCnt, dhtCnt_ff, nxt_dhtCnt;
  logic cht_ff, nxt_cht, dht_ff, nxt_dht, chg_ff, nxt_chg, term_ff, nxt_term;
  logic full_ff, nxt_full, inh_ff, nxt_inh, taperMet_ff, nxt_taperMet;
  logic [1:0] taperWin_ff, nxt_taperWin;
  logic winOk_ff, nxt_winOk;
  logic [15:0] rem_ff, nxt_rem;
  logic signed [15:0] temp_ff, nxt_temp;
  logic signed [16:0] dsgNeg, taperV;
  assign dsgNeg = -17'(dsgCurThresh);
  assign taperV = 17'(chargingVoltage) - 17'(taperVoltage);
  always_comb begin
    nxt_chtCnt = chtCnt_ff;
    nxt_dhtCnt = dhtCnt_ff;
    nxt_cht = cht_ff;
    nxt_dht = dht_ff;
    nxt_chg = chg_ff;
    nxt_term = term_ff;
    nxt_full = full_ff;
    nxt_inh = inh_ff;
    nxt_taperMet = taperMet_ff;
    nxt_taperWin = taperWin_ff;
    nxt_winOk = winOk_ff;
    nxt_rem = rem_ff;
    nxt_temp = temp_ff;
    if (measStrobe && !reportFrozen) begin
      nxt_temp = tempNow;
      nxt_rem = chargeLeftIn;
      if (meanCellFlow > 16'sh0000) begin
        nxt_chg = 1'b1;
      end
      if (chargeHeatDwell == 8'h00) begin
        nxt_cht = 1'b0;
        nxt_chtCnt = 8'h00;
      end else if (tempNow <= chargeHeatRelease) begin
        nxt_cht = 1'b0;
        nxt_chtCnt = 8'h00;
      end else if (tempNow >= chargeHeatLimit && meanCellFlow >= chgCurThresh) begin
        if (chtCnt_ff + 8'h01 >= chargeHeatDwell) begin
          nxt_cht = 1'b1;
        end else begin
          nxt_chtCnt = chtCnt_ff + 8'h01;
        end
      end else begin
        nxt_chtCnt = 8'h00;
      end
      if (dischargeHeatDwell == 8'h00) begin
        nxt_dht = 1'b0;
        nxt_dhtCnt = 8'h00;
      end else if (tempNow <= dischargeHeatRelease) begin
        nxt_dht = 1'b0;
        nxt_dhtCnt = 8'h00;
      end else if (tempNow >= dischargeHeatLimit && 17'(meanCellFlow) <= dsgNeg) begin
        if (dhtCnt_ff + 8'h01 >= dischargeHeatDwell) begin
          nxt_dht = 1'b1;
        end else begin
          nxt_dhtCnt = dhtCnt_ff + 8'h01;
        end
      end else begin
        nxt_dhtCnt = 8'h00;
      end
      if (tempNow < inhibitLow || tempNow > inhibitHigh) begin
        nxt_inh = 1'b1;
      end else if (tempNow >= inhibitLow + tempHys && tempNow <= inhibitHigh - tempHys) begin
        nxt_inh = 1'b0;
      end
      if (meanCellFlow >= taperCurrent || capGain <= capGainMin || 17'(cellVoltage) <= taperV) begin
        nxt_winOk = 1'b0;
      end
      if (meanCellFlow <= 16'sh0000) begin
        nxt_taperMet = 1'b0;
        nxt_term = 1'b0;
        nxt_full = 1'b0;
      end
      if (chargerAlarmLevel != `GSPM_LEVEL_OFF && socPercent >= chargerAlarmLevel) begin
        nxt_term = 1'b1;
      end
      if (fullDetectLevel != `GSPM_LEVEL_OFF && socPercent >= fullDetectLevel) begin
        nxt_full = 1'b1;
      end
    end
    if (taperWindowEnd) begin
      nxt_taperWin = nxt_winOk ? taperWin_ff + 2'h1 : 2'h0;
      if (nxt_winOk && taperWin_ff + 2'h1 >= 2'(`GSPM_TAPER_WINDOWS)) begin
        nxt_taperWin = 2'h0;
        nxt_chg = 1'b0;
        nxt_taperMet = 1'b1;
        nxt_term = 1'b1;
        nxt_full = 1'b1;
        if (remainingToFullOnEnd) begin
          nxt_rem = fullCapacityValue;
        end
      end
      nxt_winOk = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chtCnt_ff <= 8'h00;
      dhtCnt_ff <= 8'h00;
      cht_ff <= 1'b0;
      dht_ff <= 1'b0;
      chg_ff <= 1'b0;
      term_ff <= 1'b0;
      full_ff <= 1'b0;
      inh_ff <= 1'b0;
      taperMet_ff <= 1'b0;
      taperWin_ff <= 2'h0;
      winOk_ff <= 1'b1;
      rem_ff <= 16'h0000;
      temp_ff <= 16'sh0000;
    end else if (clkEn) begin
      chtCnt_ff <= nxt_chtCnt;
      dhtCnt_ff <= nxt_dhtCnt;
      cht_ff <= nxt_cht;
      dht_ff <= nxt_dht;
      chg_ff <= nxt_chg;
      term_ff <= nxt_term;
      full_ff <= nxt_full;
      inh_ff <= nxt_inh;
      taperMet_ff <= nxt_taperMet;
      taperWin_ff <= nxt_taperWin;
      winOk_ff <= nxt_winOk;
      rem_ff <= nxt_rem;
      temp_ff <= nxt_temp;
    end
  end

  // Power mode group.
  gspm_pkg::gspm_mode_type mode_ff, nxt_mode;
  logic [15:0] wait_ff, nxt_wait;
  logic [4:0] cal_ff, nxt_cal;
  logic [31:0] stall_ff, nxt_stall, hold_ff, nxt_hold;
  logic deepReq_ff, nxt_deepReq, dorReq_ff, nxt_dorReq, lowCell_ff, nxt_lowCell;
  logic comPrev_ff, comEdge, sleepOk, dormOk;
  logic signed [15:0] absFlow;
  assign comEdge = comAct & ~comPrev_ff;
  assign absFlow = meanCellFlow[15] ? -meanCellFlow : meanCellFlow;
  assign sleepOk = sleepEnable && meanCellFlow < sleepCurrent;
  assign dormOk = ocvValid && absFlow < dormantCurrent;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_wait = wait_ff;
    nxt_cal = cal_ff;
    nxt_stall = stall_ff;
    nxt_hold = (hold_ff != 32'h0) ? hold_ff - 32'h1 : hold_ff;
    nxt_deepReq = deepReq_ff | deepIdleSetSubcommand;
    nxt_dorReq = dorReq_ff | dormantSetSubcommand;
    nxt_lowCell = lowCell_ff;
    if ((mode_ff == gspm_pkg::SLEEP || mode_ff == gspm_pkg::DEEPIDLE) && comEdge) begin
      nxt_stall = 32'(STALL_CYC);
    end else if (stall_ff != 32'h0) begin
      nxt_stall = stall_ff - 32'h1;
    end
    case (mode_ff)
      gspm_pkg::NORMAL: begin
        if (measStrobe && dormOk && (cellVoltage < dormantVoltage || dorReq_ff)) begin
          nxt_mode = gspm_pkg::DORMANT;
          nxt_lowCell = cellVoltage < dormantVoltage;
        end else if (measStrobe && sleepOk) begin
          nxt_mode = gspm_pkg::CALIB;
          nxt_cal = 5'(`GSPM_CAL_CYC);
        end
      end
      gspm_pkg::CALIB: begin
        if (cal_ff == 5'h00) begin
          nxt_mode = gspm_pkg::SLEEP;
          nxt_wait = deepIdleWait;
        end else begin
          nxt_cal = cal_ff - 5'h01;
        end
      end
      gspm_pkg::SLEEP: begin
        if ((measStrobe && !sleepOk) || wakAct) begin
          nxt_mode = gspm_pkg::NORMAL;
        end else if (deepIdleWait == 16'h0000) begin
          if (deepReq_ff) begin
            nxt_mode = gspm_pkg::DEEPIDLE;
          end
        end else if (wait_ff == 16'h0000) begin
          nxt_mode = gspm_pkg::DEEPIDLE;
        end else if (measStrobe) begin
          nxt_wait = wait_ff - 16'h0001;
        end
      end
      gspm_pkg::DEEPIDLE: begin
        if (comEdge || (measStrobe && !sleepOk) || wakAct) begin
          nxt_mode = comEdge ? gspm_pkg::SLEEP : gspm_pkg::NORMAL;
          nxt_wait = deepIdleWait;
          if (deepIdleWait == 16'h0000) begin
            nxt_deepReq = deepIdleSetSubcommand;
          end
        end
      end
      gspm_pkg::DORMANT: begin
        if (adrAct) begin
          nxt_mode = gspm_pkg::NORMAL;
          nxt_dorReq = dormantSetSubcommand;
          nxt_lowCell = 1'b0;
          nxt_hold = 32'(HOLD_CYC);
        end
      end
      default: nxt_mode = gspm_pkg::NORMAL;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= gspm_pkg::NORMAL;
      wait_ff <= 16'h0000;
      cal_ff <= 5'h00;
      stall_ff <= 32'h0;
      hold_ff <= 32'h0;
      deepReq_ff <= 1'b0;
      dorReq_ff <= 1'b0;
      lowCell_ff <= 1'b0;
      comPrev_ff <= 1'b0;
    end else if (clkEn) begin
      mode_ff <= nxt_mode;
      wait_ff <= nxt_wait;
      cal_ff <= nxt_cal;
      stall_ff <= nxt_stall;
      hold_ff <= nxt_hold;
      deepReq_ff <= nxt_deepReq;
      dorReq_ff <= nxt_dorReq;
      lowCell_ff <= nxt_lowCell;
      comPrev_ff <= comAct;
    end
  end

  // Software reset counters, one per reset class; they saturate rather than wrap.
  logic [7:0] rstCnt_ff [`GSPM_RST_TYPES], nxt_rstCnt [`GSPM_RST_TYPES];
  for (genvar g = 0; g < `GSPM_RST_TYPES; g++) begin : gRstCnt
    always_comb begin
      nxt_rstCnt[g] = rstCnt_ff[g];
      if (resetSubcommand && resetType == 2'(g) && rstCnt_ff[g] != 8'hFF) begin
        nxt_rstCnt[g] = rstCnt_ff[g] + 8'h01;
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        rstCnt_ff[g] <= 8'h00;
      end else if (clkEn) begin
        rstCnt_ff[g] <= nxt_rstCnt[g];
      end
    end
  end

  assign batteryTemp = temp_ff;
  assign chargeHeatFlag = cht_ff;
  assign dischargeHeatFlag = dht_ff;
  assign chargingFlag = chg_ff;
  assign terminateCharge = term_ff;
  assign fullChargeFlag = full_ff;
  assign chargeBlockFlag = inh_ff;
  assign chargeLeftValue = rem_ff;
  assign deepIdleRequest = deepReq_ff;
  assign dormantRequest = dorReq_ff;
  assign powerMode = mode_ff;
  assign calibrating = (mode_ff == gspm_pkg::CALIB);
  assign hfOscOff = (mode_ff == gspm_pkg::DEEPIDLE);
  assign lineHold = (stall_ff != 32'h0);
  assign shutdownActive = (mode_ff == gspm_pkg::DORMANT) && lowCell_ff;
  assign reportFrozen = (hold_ff != 32'h0);
  assign resetCount = rstCnt_ff[resetDataSel];
endmodule // gspm_core
`default_nettype wire

//--- verification/gspm_core_asserts.sv
// Property checker for the gauge status and power mode block.
`default_nettype none
module gspm_core_asserts #(
  parameter int STALL_CYC = 20 // Line hold length.
) (
  input wire logic               ref_clk,             // Clock.
  input wire logic               rst,                 // Reset.
  input wire logic               clkEn,               // Enable.
  input wire logic               measStrobe,          // Update.
  input wire logic signed [15:0] extTemp,             // Thermistor.
  input wire logic signed [15:0] intTemp,             // On-chip.
  input wire logic               thermalSourceSelect, // Source.
  input wire logic               ocvValid,            // Relaxed.
  input wire logic        [7:0]  chargeHeatDwell,     // Dwell.
  input wire logic        [7:0]  dischargeHeatDwell,  // Dwell.
  input wire logic signed [15:0] batteryTemp,         // Temp.
  input wire logic               chargeHeatFlag,      // Flag.
  input wire logic               dischargeHeatFlag,   // Flag.
  input wire logic               dormantRequest,      // Request.
  input wire logic        [2:0]  powerMode,           // Mode.
  input wire logic               calibrating,         // Calib.
  input wire logic               hfOscOff,            // Osc off.
  input wire logic               lineHold,            // Stall.
  input wire logic               shutdownActive,      // Shutdown.
  input wire logic               reportFrozen         // Frozen.
);
  logic [31:0] holdCnt_ff, nxt_holdCnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // The counter bounds the stall so a hold that never ends is caught.
  always_comb begin
    nxt_holdCnt = lineHold ? holdCnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      holdCnt_ff <= 32'h0;
    end else begin
      holdCnt_ff <= nxt_holdCnt;
    end
  end
  temp_select_a: assert property (measStrobe && clkEn && !reportFrozen |=>
    batteryTemp == ($past(thermalSourceSelect) ? $past(extTemp) : $past(intTemp))) else $error("temp source wrong");
  calib_first_a: assert property ($rose(powerMode == gspm_pkg::SLEEP) |->
    $past(powerMode) inside {gspm_pkg::CALIB, gspm_pkg::DEEPIDLE}) else $error("sleep without calibration");
  calib_len_a: assert property ($rose(calibrating) |-> ##17 powerMode == gspm_pkg::SLEEP) else $error("calib");
  deep_entry_a: assert property ($rose(powerMode == gspm_pkg::DEEPIDLE) |->
    $past(powerMode) == gspm_pkg::SLEEP) else $error("deep idle not from sleep");
  osc_off_a: assert property (hfOscOff == (powerMode == gspm_pkg::DEEPIDLE)) else $error("osc state");
  dorm_entry_a: assert property ($rose(powerMode == gspm_pkg::DORMANT) |->
    $past(measStrobe) && $past(ocvValid)) else $error("dormant entry");
  dorm_exit_a: assert property ($past(powerMode) == gspm_pkg::DORMANT && powerMode == gspm_pkg::NORMAL |->
    !dormantRequest && reportFrozen) else $error("dormant exit");
  shut_mode_a: assert property (shutdownActive |-> powerMode == gspm_pkg::DORMANT) else $error("shutdown");
  frozen_hold_a: assert property (reportFrozen && measStrobe |=>
    $stable(batteryTemp) && $stable(chargeHeatFlag)) else $error("frozen values moved");
  chg_dwell_a: assert property ($rose(chargeHeatFlag) |-> chargeHeatDwell != 8'h00) else $error("chg");
  dsg_dwell_a: assert property ($rose(dischargeHeatFlag) |-> dischargeHeatDwell != 8'h00) else $error("dsg");
  stall_mode_a: assert property ($rose(lineHold) |->
    $past(powerMode) inside {gspm_pkg::SLEEP, gspm_pkg::DEEPIDLE}) else $error("stall outside sleep");
  stall_len_a: assert property (holdCnt_ff <= STALL_CYC) else $error("stall too long");
endmodule // gspm_core_asserts
bind gspm_core gspm_core_asserts #(.STALL_CYC(STALL_CYC)) u_gspm_core_asserts (.*);
`default_nettype wire

//--- verification/gspm_host.sv
// Host processor model issuing subcommands and bus activity.
`default_nettype none
module gspm_host #(
  parameter int STALL_CYC = 20 // Line hold length.
) (
  input  wire logic       ref_clk,               // Clock.
  input  wire logic       lineHold,              // Device stall.
  output var  logic       commActivity,          // Bus activity.
  output var  logic       commAddressed,         // Addressed activity.
  output var  logic       deepIdleSetSubcommand, // Deep idle set.
  output var  logic       dormantSetSubcommand,  // Dormant set.
  output var  logic       resetSubcommand,       // Soft reset.
  output var  logic [1:0] resetType              // Reset class.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {commActivity, commAddressed, deepIdleSetSubcommand, dormantSetSubcommand, resetSubcommand} = '0;
    resetType = 2'h0;
  end
  // Codes: 0 reset, 1 deep idle set, 2 dormant set, 3 activity, 4 addressed.
  task automatic cmd(input int k, input logic [1:0] t);
    int n;
    n = 0;
    while (lineHold === 1'b1 && n < 2 * STALL_CYC) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    resetType = t;
    case (k)
      0: resetSubcommand = 1'b1;
      1: deepIdleSetSubcommand = 1'b1;
      2: dormantSetSubcommand = 1'b1;
      default: begin
        commActivity = 1'b1;
        commAddressed = (k == 4);
      end
    endcase
    // Pins pass three sync flops, so activity is held long enough to be seen.
    repeat ((k > 2) ? 4 : 1) @(posedge ref_clk);
    #1;
    {commActivity, commAddressed, deepIdleSetSubcommand, dormantSetSubcommand, resetSubcommand} = '0;
    resetType = ~t;
  endtask
endmodule // gspm_host
`default_nettype wire

//--- verification/gspm_core_tb_top.sv
// Self-checking testbench of the gauge status and power mode block.
`default_nettype none
module gspm_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STALL_CYC = 20;
  localparam int HOLD_CYC = 50;
  logic ref_clk, rst, clkEn, measStrobe, thermalSourceSelect, taperWindowEnd, remainingToFullOnEnd, sleepEnable;
  logic wakeCompEnable, wakeCompTrip, ocvValid, commActivity, commAddressed, resetSubcommand;
  logic deepIdleSetSubcommand, dormantSetSubcommand, chargeHeatFlag, dischargeHeatFlag, chargingFlag;
  logic terminateCharge, fullChargeFlag, chargeBlockFlag, deepIdleRequest, dormantRequest, calibrating;
  logic hfOscOff, lineHold, shutdownActive, reportFrozen;
  logic [1:0] resetType, resetDataSel;
  logic [2:0] powerMode;
  logic [7:0] chargeHeatDwell, dischargeHeatDwell, resetCount;
  logic [15:0] capGain, capGainMin, fullCapacityValue, chargeLeftIn, chargerAlarmLevel, fullDetectLevel;
  logic [15:0] socPercent, deepIdleWait, chargeLeftValue;
  logic signed [15:0] extTemp, intTemp, meanCellFlow, cellVoltage, chargeHeatLimit, chargeHeatRelease, chgCurThresh;
  logic signed [15:0] dischargeHeatLimit, dischargeHeatRelease, dsgCurThresh, taperCurrent, chargingVoltage;
  logic signed [15:0] taperVoltage, inhibitLow, inhibitHigh, tempHys, sleepCurrent, dormantCurrent, dormantVoltage;
  logic signed [15:0] batteryTemp;
  logic [15:0] tv [6] = '{16'h0040, 16'h0055, 16'h0100, 16'h0210, 16'h01F8, 16'h0100};
  logic ev [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  int mismatches, n_compared, i;
  gspm_core #(.STALL_CYC(STALL_CYC), .HOLD_CYC(HOLD_CYC)) u_gspm_core (.*);
  gspm_host #(.STALL_CYC(STALL_CYC)) u_gspm_host (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic upd(input logic w);
    {measStrobe, taperWindowEnd} = {1'b1, w};
    tick(1);
    {measStrobe, taperWindowEnd} = 2'b00;
    tick(1);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 40 && powerMode !== m; k++) upd(1'b0);
    chk("powerMode", powerMode, m);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    results();
  end
  initial begin
    {ref_clk, rst, clkEn, thermalSourceSelect, remainingToFullOnEnd} = 5'b01111;
    {measStrobe, taperWindowEnd, sleepEnable, wakeCompEnable, wakeCompTrip, ocvValid, resetDataSel} = '0;
    {extTemp, intTemp, meanCellFlow, cellVoltage} = {16'h0100, 16'h0090, 16'h0000, 16'h0F80};
    {chargeHeatLimit, chargeHeatRelease, chgCurThresh, chargeHeatDwell} = {16'h0180, 16'h0140, 16'h0020, 8'h02};
    {dischargeHeatLimit, dischargeHeatRelease, dsgCurThresh, dischargeHeatDwell} = {48'h0180_0140_0020, 8'h02};
    {taperCurrent, chargingVoltage, taperVoltage, capGain, capGainMin} = 80'h0040_1000_0100_0010_0004;
    {fullCapacityValue, chargeLeftIn, chargerAlarmLevel, fullDetectLevel, socPercent} = 80'h1234_0800_FFFF_FFFF_0032;
    {inhibitLow, inhibitHigh, tempHys, sleepCurrent, deepIdleWait} = 80'h0050_0200_0010_0008_0000;
    {dormantCurrent, dormantVoltage} = {16'h0010, 16'h0400};
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    tick(1);
    upd(1'b0);
    chk("batteryTemp", batteryTemp, 16'h0100);
    thermalSourceSelect = 1'b0;
    upd(1'b0);
    chk("batteryTemp", batteryTemp, 16'h0090);
    {clkEn, thermalSourceSelect} = 2'b01;
    upd(1'b0);
    chk("batteryTemp", batteryTemp, 16'h0090);
    clkEn = 1'b1;
    for (i = 0; i < 6; i++) begin
      extTemp = tv[i];
      upd(1'b0);
      chk("chargeBlockFlag", chargeBlockFlag, ev[i]);
    end
    for (i = 0; i < 2; i++) begin
      meanCellFlow = i ? -16'sh0020 : 16'sh0030;
      extTemp = 16'h0180;
      upd(1'b0);
      chk("heatFlag", i ? dischargeHeatFlag : chargeHeatFlag, 1'b0);
      repeat (2) upd(1'b0);
      chk("heatFlag", i ? dischargeHeatFlag : chargeHeatFlag, 1'b1);
      extTemp = 16'h0140;
      upd(1'b0);
      chk("heatFlag", i ? dischargeHeatFlag : chargeHeatFlag, 1'b0);
    end
    {chargeHeatDwell, meanCellFlow, extTemp} = {8'h00, 16'h0030, 16'h0180};
    repeat (4) upd(1'b0);
    chk("chargeHeatFlag", chargeHeatFlag, 1'b0);
    extTemp = 16'h0100;
    upd(1'b0);
    chk("chargingFlag", chargingFlag, 1'b1);
    upd(1'b1);
    chk("fullChargeFlag", fullChargeFlag, 1'b0);
    chk("terminateCharge", terminateCharge, 1'b0);
    upd(1'b1);
    chk("chargingFlag", chargingFlag, 1'b0);
    chk("fullChargeFlag", fullChargeFlag, 1'b1);
    chk("terminateCharge", terminateCharge, 1'b1);
    chk("chargeLeftValue", chargeLeftValue, 16'h1234);
    meanCellFlow = 16'h0000;
    u_gspm_host.cmd(1, 2'h0);
    sleepEnable = 1'b1;
    upd(1'b0);
    chk("calibrating", calibrating, 1'b1);
    wait_mode(gspm_pkg::DEEPIDLE);
    chk("hfOscOff", hfOscOff, 1'b1);
    u_gspm_host.cmd(3, 2'h0);
    tick(6);
    chk("powerMode", powerMode, gspm_pkg::SLEEP);
    chk("deepIdleRequest", deepIdleRequest, 1'b0);
    {wakeCompEnable, wakeCompTrip} = 2'b11;
    tick(5);
    chk("powerMode", powerMode, gspm_pkg::NORMAL);
    {wakeCompTrip, sleepEnable} = 2'b00;
    u_gspm_host.cmd(2, 2'h0);
    ocvValid = 1'b1;
    upd(1'b0);
    chk("powerMode", powerMode, gspm_pkg::DORMANT);
    chk("shutdownActive", shutdownActive, 1'b0);
    u_gspm_host.cmd(4, 2'h0);
    tick(6);
    chk("powerMode", powerMode, gspm_pkg::NORMAL);
    chk("dormantRequest", dormantRequest, 1'b0);
    chk("reportFrozen", reportFrozen, 1'b1);
    {extTemp, ocvValid} = {16'h0120, 1'b0};
    upd(1'b0);
    chk("batteryTemp", batteryTemp, 16'h0100);
    tick(HOLD_CYC);
    chk("reportFrozen", reportFrozen, 1'b0);
    repeat (2) u_gspm_host.cmd(0, 2'h2);
    resetDataSel = 2'h2;
    tick(2);
    chk("resetCount", resetCount, 16'h0002);
    resetDataSel = 2'h1;
    tick(1);
    chk("resetCount", resetCount, 16'h0000);
    {deepIdleWait, sleepEnable} = {16'h0002, 1'b1};
    wait_mode(gspm_pkg::DEEPIDLE);
    meanCellFlow = 16'sh0020;
    wait_mode(gspm_pkg::NORMAL);
    results();
  end
endmodule // gspm_core_tb_top
`default_nettype wire
